// ===== rtl/adc_ctrl_pkg.sv
// shared constants of the dual converter control and readout logic
// assumes a single 250 MHz clock; all strobes arrive synchronous to it
// What the document requires of this block and its host
// R01 - Bipolar ranges give each result as 14-bit twos complement, one step being full scale over 16,384.
// R02 - The unipolar range gives each result as 14-bit straight binary, one step being full scale over 16,384.
// R03 - Bipolar most negative is 10 0000 0000 0000, most positive 01 1111 1111 1111, zero between all ones and all zeros.
// R04 - A falling conversion start puts both track-and-holds into hold together and starts both conversions.
// R05 - Both new results sit in the output register 5.2 us after the conversion start falling edge.
// R06 - Busy ending marks the end of conversion, after which both results can be read.
// R07 - Busy goes high on the conversion start falling edge and low when the conversion completes.
// R08 - With the pair select low, the first read returns the first A input and the second read the second A input.
// R09 - With the pair select high, the two reads return the first and then the second B input.
// R10 - The host changes the pair select only after conversion start is high again, stable 500 ns before the next start.
// R11 - The host keeps the pair select still during conversion when unselected inputs are driven far negative.
// R12 - A read is one low chip select pulse holding two low read strobe pulses, each giving one 14-bit result.
// R13 - The host leaves at least 400 ns between the end of a read and the next conversion start falling edge.
// R14 - The host plans on a 5.7 us least cycle: conversion time, a 100 ns read and the quiet time.
// R15 - Other chip select and read strobe patterns read the inputs in other combinations than the plain two reads.
// R16 - The data bus is driven only while chip select and read strobe are both low, and released otherwise; the code's O_DATA_OE lags them by one clock.
package adc_ctrl_pkg;

   localparam int          CLK_PERIOD_PS   = 4000;
   localparam int          CONV_TIME_PS    = 5200000;
   // longest time, so rounded down
   localparam int          CONV_CYCLES     = CONV_TIME_PS / CLK_PERIOD_PS;

   localparam int          RESULT_W        = 14;
   localparam int          FULL_SCALE_STEPS = 16384;
   localparam int          SIGN_BIT        = 13;
   localparam logic [13:0] SIGN_FLIP       = 14'h2000;
   localparam logic [13:0] BIPOLAR_MIN     = 14'h2000;
   localparam logic [13:0] BIPOLAR_MAX     = 14'h1FFF;
   localparam logic [13:0] DATA_RESET      = 14'h0000;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_CONV = 2'b10
   } conv_state_e;

endpackage

// ===== rtl/code_format.sv
// output coding of one converted sample
// raw input is offset binary from the bottom of the range
`timescale 1ns/1ps
module code_format
   import adc_ctrl_pkg::*;
#(
   parameter int W = RESULT_W
) (
   // sample
   input  wire logic [W-1:0] i_raw,
   input  wire logic         i_bipolar,
   // coded result
   output logic      [W-1:0] o_code
);

   // flipping the top bit maps offset binary onto twos complement
   wire logic [W-1:0] twos_code = {~i_raw[W-1], i_raw[W-2:0]};  // [R01] [R03]

   assign o_code = i_bipolar ? twos_code : i_raw;  // [R02]

endmodule // code_format

// ===== rtl/conv_timer.sv
// fixed length conversion timer, the stand-in for the internal conversion clock
// start is a one-cycle pulse; a start while running is ignored
`timescale 1ns/1ps
module conv_timer #(
   parameter int CYCLES = 1300
) (
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_reset,
   // control
   input  wire logic i_start,
   output logic      o_done
);

   localparam int CW = $clog2(CYCLES + 1);

   logic [CW-1:0] count_q;
   logic          run_q;

   assign o_done = run_q && (count_q == CW'(CYCLES));  // [R05]

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         run_q   <= 1'b0;
         count_q <= '0;
      end else if (i_start && !run_q) begin
         run_q   <= 1'b1;
         count_q <= CW'(1);
      end else if (o_done) begin
         run_q   <= 1'b0;
         count_q <= '0;
      end else if (run_q) begin
         count_q <= count_q + CW'(1);
      end
   end

endmodule // conv_timer

// ===== rtl/dual_adc_conversion_read_control.sv
// conversion start, busy and parallel result readout of a dual sampling converter
// the analog front end hands in four offset-binary samples; bus pins are synchronous
`timescale 1ns/1ps
module dual_adc_conversion_read_control
   import adc_ctrl_pkg::*;
#(
   parameter int W         = RESULT_W,
   parameter int CONV_CYC  = CONV_CYCLES
) (
   // clock and reset
   input  wire logic         I_CLK,
   input  wire logic         I_RESET,
   // conversion control
   input  wire logic         I_CONVERSION_START_N,
   input  wire logic         I_CHANNEL_PAIR_SELECT,
   input  wire logic         I_RANGE_BIPOLAR,
   // sampled inputs, offset binary
   input  wire logic [W-1:0] I_PAIR_A_INPUT_FIRST,
   input  wire logic [W-1:0] I_PAIR_A_INPUT_SECOND,
   input  wire logic [W-1:0] I_PAIR_B_INPUT_FIRST,
   input  wire logic [W-1:0] I_PAIR_B_INPUT_SECOND,
   // parallel read bus
   input  wire logic         I_CS_N,
   input  wire logic         I_RD_N,
   output logic      [W-1:0] O_DATA,
   output logic              O_DATA_OE,
   // status
   output logic              O_BUSY,
   output logic              O_HOLD
);

   conv_state_e    state_q;
   conv_state_e    state_d;

   logic           start_n_prev_q;
   logic           rd_n_prev_q;
   logic           cs_n_prev_q;

   logic           pair_sel_q;
   logic           bipolar_q;
   logic [W-1:0]   hold_first_q;
   logic [W-1:0]   hold_second_q;
   logic [W-1:0]   result_first_q;
   logic [W-1:0]   result_second_q;
   logic           read_ptr_q;

   logic [W-1:0]   coded_first;
   logic [W-1:0]   coded_second;
   logic           conv_done;

   // edge detection on the synchronous pins
   wire logic      start_fall = start_n_prev_q && !I_CONVERSION_START_N;
   wire logic      idle       = (state_q == ST_IDLE);
   wire logic      take_start = start_fall && idle;  // [R04]
   wire logic      rd_fall    = rd_n_prev_q && !I_RD_N && !I_CS_N;
   // a strobe counts as done when it rises with chip select still low
   wire logic      rd_done    = !rd_n_prev_q && I_RD_N && !cs_n_prev_q;  // [R12]
   wire logic      drive      = !I_CS_N && !I_RD_N;  // [R16]

   // pair select picks which input pair goes into hold
   wire logic [W-1:0] pick_first  = I_CHANNEL_PAIR_SELECT ? I_PAIR_B_INPUT_FIRST  : I_PAIR_A_INPUT_FIRST;  // [R08] [R09]
   wire logic [W-1:0] pick_second = I_CHANNEL_PAIR_SELECT ? I_PAIR_B_INPUT_SECOND : I_PAIR_A_INPUT_SECOND; // [R08] [R09]
   wire logic [W-1:0] read_word   = read_ptr_q ? result_second_q : result_first_q;

   conv_timer #(
      .CYCLES (CONV_CYC)
   ) u_timer (
      .i_clk   (I_CLK),
      .i_reset (I_RESET),
      .i_start (take_start),
      .o_done  (conv_done)
   );

   code_format #(
      .W (W)
   ) u_fmt_first (
      .i_raw     (hold_first_q),
      .i_bipolar (bipolar_q),
      .o_code    (coded_first)
   );

   code_format #(
      .W (W)
   ) u_fmt_second (
      .i_raw     (hold_second_q),
      .i_bipolar (bipolar_q),
      .o_code    (coded_second)
   );

   // a start during a conversion is ignored; only reset cuts the running one short
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (take_start) begin
               state_d = ST_CONV;  // [R04]
            end
         end
         ST_CONV: begin
            if (conv_done) begin
               state_d = ST_IDLE;  // [R06]
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         state_q        <= ST_IDLE;
         start_n_prev_q <= 1'b1;
         rd_n_prev_q    <= 1'b1;
         cs_n_prev_q    <= 1'b1;
      end else begin
         state_q        <= state_d;
         start_n_prev_q <= I_CONVERSION_START_N;
         rd_n_prev_q    <= I_RD_N;
         cs_n_prev_q    <= I_CS_N;
      end
   end

   // both samples frozen in the same cycle
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         pair_sel_q    <= 1'b0;
         bipolar_q     <= 1'b0;
         hold_first_q  <= DATA_RESET;
         hold_second_q <= DATA_RESET;
      end else if (take_start) begin
         pair_sel_q    <= I_CHANNEL_PAIR_SELECT;
         bipolar_q     <= I_RANGE_BIPOLAR;
         hold_first_q  <= pick_first;  // [R04]
         hold_second_q <= pick_second; // [R04]
      end
   end

   // output register loads only at the end, so old results stay readable during conversion
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         result_first_q  <= DATA_RESET;
         result_second_q <= DATA_RESET;
      end else if (conv_done) begin
         result_first_q  <= coded_first;  // [R05] [R01] [R02]
         result_second_q <= coded_second; // [R05] [R01] [R02]
      end
   end

   // read pointer: first strobe after a conversion gives the first input;
   // further strobes wrap, which lets other strobe patterns re-read a word
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         read_ptr_q <= 1'b0;
      end else if (conv_done) begin
         read_ptr_q <= 1'b0;  // [R08] [R09]
      end else if (rd_done) begin
         read_ptr_q <= ~read_ptr_q;  // [R12] [R15]
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         O_DATA    <= DATA_RESET;
         O_DATA_OE <= 1'b0;
      end else begin
         O_DATA_OE <= drive;  // [R16]
         if (rd_fall || drive) begin
            O_DATA <= read_word;  // [R12]
         end
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         O_BUSY <= 1'b0;
         O_HOLD <= 1'b0;
      end else begin
         O_BUSY <= (state_d == ST_CONV);  // [R07] [R06]
         O_HOLD <= (state_d == ST_CONV);  // [R04]
      end
   end

   // checking
   logic [15:0] busy_len_q;

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         busy_len_q <= 16'h0000;
      end else if (O_BUSY) begin
         busy_len_q <= busy_len_q + 16'h0001;
      end else begin
         busy_len_q <= 16'h0000;
      end
   end

   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (I_RESET);

   a_busy_rises_start: assert property ( // [R07]
      (start_fall && idle) |=> O_BUSY && O_HOLD
   ) else $error("busy not raised by conversion start");

   // a reset in mid-conversion also drops busy, so that fall is not a finished conversion
   a_busy_exact_length: assert property ( // [R05]
      ($fell(O_BUSY) && !$past(I_RESET)) |-> (busy_len_q == 16'(CONV_CYC))
   ) else $error("conversion did not last the set time");

   a_results_at_end: assert property ( // [R06]
      $fell(O_BUSY) |-> (result_first_q == coded_first) && (result_second_q == coded_second) && (read_ptr_q == 1'b0)
   ) else $error("results not loaded when busy ended");

   a_busy_ignores_start: assert property ( // [R04]
      (O_BUSY && start_fall) |=> $stable(hold_first_q) && $stable(hold_second_q) && $stable(pair_sel_q)
   ) else $error("held samples changed during a conversion");

   a_bipolar_coding: assert property ( // [R01]
      ($fell(O_BUSY) && bipolar_q) |-> (result_first_q == (hold_first_q ^ SIGN_FLIP))
   ) else $error("bipolar result not twos complement");

   a_bipolar_extremes: assert property ( // [R03]
      ($fell(O_BUSY) && bipolar_q && (hold_second_q == 14'h0000)) |-> (result_second_q == BIPOLAR_MIN)
   ) else $error("bipolar most negative code wrong");

   a_unipolar_coding: assert property ( // [R02]
      ($fell(O_BUSY) && !bipolar_q) |-> (result_first_q == hold_first_q) && (result_second_q == hold_second_q)
   ) else $error("unipolar result not straight binary");

   a_first_read_word: assert property ( // [R08]
      (rd_fall && (read_ptr_q == 1'b0) && !conv_done) |=> (O_DATA == result_first_q) && O_DATA_OE
   ) else $error("first read did not return the first input");

   a_second_read_word: assert property ( // [R09]
      (rd_done && (read_ptr_q == 1'b0) && !conv_done) ##1 (rd_fall && !conv_done) |=> (O_DATA == result_second_q)
   ) else $error("second read did not return the second input");

   a_bus_released: assert property ( // [R16]
      ($past(I_CS_N) || $past(I_RD_N)) |-> !O_DATA_OE
   ) else $error("data bus driven outside a read strobe");

endmodule // dual_adc_conversion_read_control

// ===== testbench/host_model.sv
// host side model: conversion start, pair select, chip select and read strobe
// assumes the block samples every pin on the rising edge of i_clk
`timescale 1ns/1ps
module host_model (
   // clock
   input  wire logic        i_clk,
   // to the block
   output logic             o_conversion_start_n,
   output logic             o_channel_pair_select,
   output logic             o_cs_n,
   output logic             o_rd_n,
   // from the block
   input  wire logic [13:0] i_data,
   input  wire logic        i_data_oe
);
   initial begin
      o_conversion_start_n  = 1'b1;
      o_channel_pair_select = 1'b0;
      o_cs_n                = 1'b1;
      o_rd_n                = 1'b1;
   end

   // select moves only while start is high; settle covers select and read quiet time
   task automatic start(input logic sel, input int settle);
      @(posedge i_clk);
      o_channel_pair_select <= sel;
      repeat (settle) @(posedge i_clk);
      o_conversion_start_n <= 1'b0;
      @(posedge i_clk);
      o_conversion_start_n <= 1'b1;
   endtask

   task automatic select_chip(input logic v);
      @(posedge i_clk);
      o_cs_n <= v;
   endtask

   // one strobe; bus sampled mid-cycle where it has settled
   task automatic read_word(output logic [13:0] d, output logic oe);
      @(posedge i_clk);
      o_rd_n <= 1'b0;
      @(posedge i_clk);
      @(negedge i_clk);
      // a released bus reads back as the inverse of its last word, so a late drive shows
      d  = i_data_oe ? i_data : ~i_data;
      oe = i_data_oe;
      @(posedge i_clk);
      o_rd_n <= 1'b1;
   endtask
endmodule // host_model

// ===== testbench/tb_dual_adc_conversion_read_control.sv
// self-checking bench of the dual converter control and readout block
// assumes host_model drives the bus pins; short conversion count for speed
`timescale 1ns/1ps
module tb_dual_adc_conversion_read_control;
   import adc_ctrl_pkg::*;
   localparam int CONV  = 20;
   localparam int LIMIT = 5000;
   logic        clk, reset, range_bipolar, start_n, sel, cs_n, rd_n, data_oe, busy, hold;
   logic [13:0] a1, a2, b1, b2, data;
   int          fail_count, check_count, cycles;

   dual_adc_conversion_read_control #(.CONV_CYC(CONV)) i_dut (
      .I_CLK(clk), .I_RESET(reset), .I_CONVERSION_START_N(start_n),
      .I_CHANNEL_PAIR_SELECT(sel), .I_RANGE_BIPOLAR(range_bipolar),
      .I_PAIR_A_INPUT_FIRST(a1), .I_PAIR_A_INPUT_SECOND(a2),
      .I_PAIR_B_INPUT_FIRST(b1), .I_PAIR_B_INPUT_SECOND(b2),
      .I_CS_N(cs_n), .I_RD_N(rd_n), .O_DATA(data), .O_DATA_OE(data_oe),
      .O_BUSY(busy), .O_HOLD(hold));

   host_model i_host (
      .i_clk(clk), .o_conversion_start_n(start_n), .o_channel_pair_select(sel),
      .o_cs_n(cs_n), .o_rd_n(rd_n), .i_data(data), .i_data_oe(data_oe));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         fail_count++;
         $display("ERROR at %0t: run hung", $time);
         complete_run();
      end
   end

   task automatic check(input logic [13:0] got, input logic [13:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // twos complement result is the offset of the raw sample from mid-scale
   function automatic logic [13:0] coded(input logic [13:0] raw, input logic bip);
      return bip ? 14'(raw - FULL_SCALE_STEPS / 2) : raw;
   endfunction

   task automatic wait_idle(output int n);
      n = 0;
      while (busy === 1'b1 && n < 100) begin
         n++;
         @(negedge clk);
      end
   endtask

   task automatic convert(input logic bip, input logic s, input logic [13:0] v[4]);
      int n;
      @(posedge clk);
      range_bipolar <= bip;
      a1 <= v[0];
      a2 <= v[1];
      b1 <= v[2];
      b2 <= v[3];
      i_host.start(s, 125);
      @(negedge clk);
      check({13'h0, busy & hold}, 14'h1, "busy and hold after start");
      wait_idle(n);
      check(n[13:0], 14'(CONV), "busy length");
      check({13'h0, hold}, 14'h0, "hold released");
   endtask

   // words read with chip select, plus a strobe without it
   task automatic read_pair(input logic [13:0] e1, input logic [13:0] e2);
      logic [13:0] d;
      logic        oe;
      i_host.read_word(d, oe);
      check({13'h0, oe}, 14'h0, "bus driven without chip select");
      i_host.select_chip(1'b0);
      i_host.read_word(d, oe);
      check({13'h0, oe}, 14'h1, "bus enable");
      check(d, e1, "first word");
      i_host.read_word(d, oe);
      check(d, e2, "second word");
      i_host.read_word(d, oe);
      check(d, e1, "third word wraps");
      i_host.select_chip(1'b1);
      @(negedge clk);
      check({13'h0, data_oe}, 14'h0, "bus released");
   endtask

   task automatic test_pairs();
      logic [13:0] v[4];
      v = '{14'h0123, 14'h3456, 14'h2ABC, 14'h1DEF};
      for (int k = 0; k < 4; k++) begin
         convert(k[1], k[0], v);
         if (k[0])
            read_pair(coded(v[2], k[1]), coded(v[3], k[1]));
         else
            read_pair(coded(v[0], k[1]), coded(v[1], k[1]));
      end
      $display("test_pairs done");
   endtask

   task automatic test_extremes();
      convert(1'b1, 1'b0, '{14'h0000, 14'h3FFF, 14'h1FFF, 14'h2000});
      read_pair(14'h2000, 14'h1FFF);
      convert(1'b1, 1'b1, '{14'h0000, 14'h3FFF, 14'h1FFF, 14'h2000});
      read_pair(14'h3FFF, 14'h0000);
      convert(1'b0, 1'b0, '{14'h0000, 14'h3FFF, 14'h1FFF, 14'h2000});
      read_pair(14'h0000, 14'h3FFF);
      $display("test_extremes done");
   endtask

   // a second start in mid-conversion must neither restart nor resample
   task automatic test_refused();
      int n;
      @(posedge clk);
      range_bipolar <= 1'b0;
      a1 <= 14'h0AAA;
      a2 <= 14'h1555;
      i_host.start(1'b0, 125);
      repeat (5) @(posedge clk);
      a1 <= 14'h3000;
      a2 <= 14'h0001;
      i_host.start(1'b0, 0);
      @(negedge clk);
      wait_idle(n);
      check(n[13:0], 14'(CONV - 7), "busy after ignored start");
      read_pair(14'h0AAA, 14'h1555);
      $display("test_refused done");
   endtask

   // a one-cycle reset in mid-conversion drops busy and leaves the block ready for a new start
   task automatic test_reset();
      logic [13:0] v[4];
      v = '{14'h0F0F, 14'h30F0, 14'h0001, 14'h3FFE};
      @(posedge clk);
      range_bipolar <= 1'b1;
      i_host.start(1'b1, 125);
      repeat (3) @(posedge clk);
      reset <= 1'b1;
      @(posedge clk);
      reset <= 1'b0;
      repeat (2) begin
         @(negedge clk);
         check({12'h0, busy, hold}, 14'h0, "status after mid-run reset");
      end
      check(data, 14'h0000, "data after mid-run reset");
      convert(1'b0, 1'b1, v);
      read_pair(v[2], v[3]);
      $display("test_reset done");
   endtask

   initial begin
      reset         = 1'b1;
      range_bipolar = 1'b0;
      a1            = 14'h0000;
      a2            = 14'h0000;
      b1            = 14'h0000;
      b2            = 14'h0000;
      fail_count    = 0;
      check_count   = 0;
      cycles        = 0;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      @(negedge clk);
      check({11'h0, busy, hold, data_oe}, 14'h0, "status after reset");
      check(data, 14'h0000, "data after reset");
      test_pairs();
      test_extremes();
      test_refused();
      test_reset();
      complete_run();
   end
endmodule // tb_dual_adc_conversion_read_control
